/* dcp_ctrl.sv */
// Control pin handling of a DDR2 device: power states, command decode, masks and termination.
// Function
// - A high registered clock enable runs the internal clocking and a low one stops it.
// - Low clock enable: precharge power-down or self refresh if idle, active power-down if not; a refresh at entry gives self refresh even with rows open.
// - Clock enable is sampled on the clock for power-down entry and exit and self refresh entry.
// - Self refresh exit follows clock enable seen high on a clock edge, as for power-down exit.
// - In power-down only clock, clock enable and termination receivers stay on.
// - In self refresh only the clock enable receiver stays on.
// - A low registered chip select enables the decoder and a high one masks every command.
// - Chip select, row strobe, column strobe and write enable together encode the command.
// - A write beat whose mask is sampled high is discarded.
// - The mask is sampled on both strobe edges, one bit per data beat.
// - On x16 the lower mask gates data 7..0 and the upper mask gates data 15..8.
// - A registered high termination input switches on internal termination.
// - Termination applies only to the data group pins of the configured width.
// - With termination disabled by a mode register load, the termination input is ignored.
// - The data bus is 16, 8 or 4 bits wide by configuration.
// - Address and control are sampled at the rising true clock crossing.
`timescale 1ns/1ps
`include "dcp_map.svh"
module dcp_ctrl #(
	parameter int DQ_W = `DCP_DQ_W_DEF
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [`DCP_BA_W-1:0] ba_i,
	input wire logic [`DCP_A_W-1:0] addr_i,
	input wire logic odt_i,
	input wire logic [DQ_W-1:0] dq_i,
	input wire logic [1:0] dm_i,
	input wire logic dqs_i,
	output logic clk_run_o,
	output dcp_pkg::dcp_pwr_t pwr_state_o,
	output logic [2:0] rx_en_o,
	output logic cmd_valid_o,
	output dcp_pkg::dcp_cmd_t cmd_o,
	output logic [`DCP_BA_W-1:0] cmd_ba_o,
	output logic [`DCP_A_W-1:0] cmd_addr_o,
	output logic [DQ_W-1:0] term_en_o,
	output logic [1:0] term_mask_en_o,
	output logic wr_valid_o,
	output logic [DQ_W-1:0] wr_data_o,
	output logic [DQ_W-1:0] wr_bit_en_o
);
	import dcp_pkg::*;

	// Only the three device widths are built; any other stops elaboration.
	if (DQ_W != 16 && DQ_W != 8 && DQ_W != 4) begin : g_bad_width
		$error("dcp_ctrl: DQ_W must be 4, 8 or 16");
	end

	// Control pin synchronisers; the first stage feeds only the second.
	logic [6:0] pin_s1_reg;
	logic [6:0] pin_s2_reg;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// Reset shows idle pins with the enable high, so no false enable edge follows.
			pin_s1_reg <= `DCP_PIN_RST;
			pin_s2_reg <= `DCP_PIN_RST;
		end else begin
			// Sampled on the rising clock, the true clock crossing.
			pin_s1_reg <= {dqs_i, odt_i, we_n_i, cas_n_i, ras_n_i, cs_n_i, cke_i};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// Write data and masks share the control pins' latency so beats line up with strobes.
	logic [DQ_W+1:0] dat_s1_reg;
	logic [DQ_W+1:0] dat_s2_reg;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dat_s1_reg <= '0;
			dat_s2_reg <= '0;
		end else begin
			dat_s1_reg <= {dm_i, dq_i};
			dat_s2_reg <= dat_s1_reg;
		end
	end

	// Bank and address take the same two stages so they stay aligned with the command.
	logic [`DCP_BA_W+`DCP_A_W-1:0] adr_s1_reg;
	logic [`DCP_BA_W+`DCP_A_W-1:0] adr_s2_reg;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			adr_s1_reg <= '0;
			adr_s2_reg <= '0;
		end else begin
			adr_s1_reg <= {ba_i, addr_i};
			adr_s2_reg <= adr_s1_reg;
		end
	end

	// Bank and row fields of the synchronised address, named once for every reader.
	logic [`DCP_BA_W-1:0] bank_s;
	logic [`DCP_A_W-1:0] row_s;
	assign bank_s = adr_s2_reg[`DCP_BA_W+`DCP_A_W-1:`DCP_A_W];
	assign row_s = adr_s2_reg[`DCP_A_W-1:0];

	// Named views of the second stage; nothing reads the first stage directly.
	logic cke_s;
	logic cs_n_s;
	logic ras_n_s;
	logic cas_n_s;
	logic we_n_s;
	logic odt_s;
	logic dqs_s;
	assign cke_s = pin_s2_reg[0];
	assign cs_n_s = pin_s2_reg[1];
	assign ras_n_s = pin_s2_reg[2];
	assign cas_n_s = pin_s2_reg[3];
	assign we_n_s = pin_s2_reg[4];
	assign odt_s = pin_s2_reg[5];
	assign dqs_s = pin_s2_reg[6];

	logic [2:0] rx_en_next;
	dcp_pwr_t pwr_reg;

	// Power-down keeps clock, enable and termination listening; self refresh only the enable.
	// Receiver gating per power state: bit0 cke, bit1 clock and odt, bit2 command/data.
	always_comb begin
		case (pwr_reg)
			DCP_ST_ACTIVE: rx_en_next = 3'h7;
			DCP_ST_PRE_PD: rx_en_next = 3'h3;
			DCP_ST_ACT_PD: rx_en_next = 3'h3;
			DCP_ST_SELF_REF: rx_en_next = 3'h1;
			default: rx_en_next = 3'h7;
		endcase
	end

	logic cmd_rx;
	assign cmd_rx = (pwr_reg == DCP_ST_ACTIVE);

	// Command decode from the four control pins, gated by chip select.
	// A switched-off receiver or a low enable reads as deselect, just like a high select.
	dcp_cmd_t cmd_next;
	always_comb begin
		if (!cmd_rx || !cke_s || cs_n_s) begin
			cmd_next = DCP_C_DESELECT;
		end else begin
			cmd_next = dcp_cmd_t'({1'b0, ras_n_s, cas_n_s, we_n_s});
		end
	end

	// Open row tracking decides which power-down flavour applies.
	// A precharge with the auto-precharge address bit high closes every bank at once.
	logic [`DCP_BANKS-1:0] open_reg;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			open_reg <= '0;
		end else if (cmd_next == DCP_C_ACTIVATE) begin
			open_reg[bank_s] <= 1'b1;
		end else if (cmd_next == DCP_C_PRECHARGE) begin
			if (row_s[`DCP_A_AP_BIT]) begin
				open_reg <= '0;
			end else begin
				open_reg[bank_s] <= 1'b0;
			end
		end
	end

	// Power state machine; clocked entry and power-down exit on the sampled clock enable.
	logic cke_prev_reg;
	logic refresh_req;
	assign refresh_req = cmd_rx && !cs_n_s && !ras_n_s && !cas_n_s && we_n_s;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pwr_reg <= DCP_ST_ACTIVE;
			cke_prev_reg <= 1'b1;
		end else begin
			cke_prev_reg <= cke_s;
			// Self refresh entry needs the refresh code in the very cycle the enable falls;
			// a refresh one cycle later is masked by the power-down that has begun.
			case (pwr_reg)
				DCP_ST_ACTIVE: begin
					if (cke_prev_reg && !cke_s) begin
						if (refresh_req) begin
							pwr_reg <= DCP_ST_SELF_REF;
						end else if (open_reg != '0) begin
							pwr_reg <= DCP_ST_ACT_PD;
						end else begin
							pwr_reg <= DCP_ST_PRE_PD;
						end
					end
				end
				DCP_ST_PRE_PD, DCP_ST_ACT_PD: begin
					// Power-down exit is clocked: the enable must be seen high on an edge.
					if (cke_s) begin
						pwr_reg <= DCP_ST_ACTIVE;
					end
				end
				DCP_ST_SELF_REF: begin
					// Self refresh exit is clocked as well: the enable must be seen high on an edge.
					if (cke_s) begin
						pwr_reg <= DCP_ST_ACTIVE;
					end
				end
				default: pwr_reg <= DCP_ST_ACTIVE;
			endcase
		end
	end

	// Clocking runs only while clock enable is registered high.
	// Power state and receiver enables leave here too, so every top output is a flip-flop.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_run_o <= 1'b1;
			pwr_state_o <= DCP_ST_ACTIVE;
			rx_en_o <= 3'h7;
		end else begin
			clk_run_o <= cke_s;
			pwr_state_o <= pwr_reg;
			rx_en_o <= rx_en_next;
		end
	end

	// Registered command outputs.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_valid_o <= 1'b0;
			cmd_o <= DCP_C_DESELECT;
			cmd_ba_o <= '0;
			cmd_addr_o <= '0;
		end else begin
			cmd_valid_o <= (cmd_next != DCP_C_DESELECT) && (cmd_next != DCP_C_NOP);
			cmd_o <= cmd_next;
			cmd_ba_o <= bank_s;
			cmd_addr_o <= row_s;
		end
	end

	// Termination enable held by the extended mode register; reset leaves it off.
	logic rtt_on_reg;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rtt_on_reg <= `DCP_ODT_RST;
		end else if (cmd_next == DCP_C_LOAD_MODE && bank_s == `DCP_EMR_SEL) begin
			rtt_on_reg <= row_s[`DCP_EMR_RTT0_BIT] | row_s[`DCP_EMR_RTT1_BIT];
		end
	end

	// Termination acts on the data group only; the mask lanes follow width.
	// Self refresh shuts the termination receiver, so termination drops with it.
	logic term_on;
	assign term_on = odt_s && rtt_on_reg && (pwr_reg != DCP_ST_SELF_REF);
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			term_en_o <= '0;
			term_mask_en_o <= 2'h0;
		end else begin
			term_en_o <= {DQ_W{term_on}};
			term_mask_en_o <= {(DQ_W == 16) && term_on, term_on};
		end
	end

	// Write burst window: data beats are taken on both strobe edges while writing.
	// The window stays open over no-operations, so a burst may span idle command slots.
	logic wr_act_reg;
	logic dqs_prev_reg;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_act_reg <= 1'b0;
			dqs_prev_reg <= 1'b0;
		end else begin
			dqs_prev_reg <= dqs_s;
			if (cmd_next == DCP_C_WRITE) begin
				wr_act_reg <= 1'b1;
			end else if (cmd_next != DCP_C_DESELECT && cmd_next != DCP_C_NOP) begin
				wr_act_reg <= 1'b0;
			end
		end
	end

	// The mask lane module turns per-byte masks into per-bit enables.
	dcp_mask_if #(.DQ_W(DQ_W)) mif ();
	assign mif.beat_valid = wr_act_reg && (dqs_s != dqs_prev_reg) && rx_en_next[2];
	assign mif.beat_data = dat_s2_reg[DQ_W-1:0];
	assign mif.beat_mask = {(DQ_W == 16) ? dat_s2_reg[DQ_W+1] : dat_s2_reg[DQ_W],
		dat_s2_reg[DQ_W]};

	dcp_mask_lane #(.DQ_W(DQ_W)) u_lane (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.mif(mif)
	);

	// Final output stage keeps every top output straight from a flip-flop.
	// The lane is already registered; this stage trades one cycle of latency for clean outputs.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_valid_o <= 1'b0;
			wr_data_o <= '0;
			wr_bit_en_o <= '0;
		end else begin
			wr_valid_o <= mif.out_valid;
			wr_data_o <= mif.out_data;
			wr_bit_en_o <= mif.out_bit_en;
		end
	end
endmodule

/* dcp_map.svh */
// Constants for the control pin handling block: command codes, mode register bits and widths.
`ifndef DCP_MAP_SVH
`define DCP_MAP_SVH
`define DCP_CMD_W 4
`define DCP_CMD_DESELECT 4'h8
`define DCP_CMD_LOAD_MODE 4'h0
`define DCP_CMD_REFRESH 4'h1
`define DCP_CMD_PRECHARGE 4'h2
`define DCP_CMD_ACTIVATE 4'h3
`define DCP_CMD_WRITE 4'h4
`define DCP_CMD_READ 4'h5
`define DCP_CMD_BURST_TERM 4'h6
`define DCP_CMD_NOP 4'h7
`define DCP_EMR_SEL 3'h1
`define DCP_EMR_RTT0_BIT 2
`define DCP_EMR_RTT1_BIT 6
`define DCP_ODT_RST 1'b0
`define DCP_PIN_RST 7'h1F
`define DCP_A_AP_BIT 10
`define DCP_BANKS 8
`define DCP_DQ_W_DEF 16
`define DCP_BA_W 3
`define DCP_A_W 15
`endif

/* dcp_pkg.sv */
// Types shared by the control pin handling block.
package dcp_pkg;
	typedef enum logic [3:0] {
		DCP_ST_ACTIVE = 4'h1,
		DCP_ST_PRE_PD = 4'h2,
		DCP_ST_ACT_PD = 4'h4,
		DCP_ST_SELF_REF = 4'h8
	} dcp_pwr_t;
	typedef enum logic [3:0] {
		DCP_C_LOAD_MODE = 4'h0,
		DCP_C_REFRESH = 4'h1,
		DCP_C_PRECHARGE = 4'h2,
		DCP_C_ACTIVATE = 4'h3,
		DCP_C_WRITE = 4'h4,
		DCP_C_READ = 4'h5,
		DCP_C_BURST_TERM = 4'h6,
		DCP_C_NOP = 4'h7,
		DCP_C_DESELECT = 4'h8
	} dcp_cmd_t;
endpackage

/* dcp_mask_if.sv */
// Interface carrying one write beat and its byte masks to the mask lane module.
`timescale 1ns/1ps
interface dcp_mask_if #(parameter int DQ_W = 16);
	logic beat_valid;
	logic [DQ_W-1:0] beat_data;
	logic [1:0] beat_mask;
	logic out_valid;
	logic [DQ_W-1:0] out_data;
	logic [DQ_W-1:0] out_bit_en;
	modport src (output beat_valid, output beat_data, output beat_mask,
		input out_valid, input out_data, input out_bit_en);
	modport lane (input beat_valid, input beat_data, input beat_mask,
		output out_valid, output out_data, output out_bit_en);
endinterface

/* dcp_mask_lane.sv */
// Write data mask module: turns per-byte mask bits into per-bit write enables.
`timescale 1ns/1ps
`include "dcp_map.svh"
module dcp_mask_lane #(
	parameter int DQ_W = `DCP_DQ_W_DEF
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	dcp_mask_if.lane mif
);
	import dcp_pkg::*;

	// Bytes are split by bit index, so any width up to two bytes is served.
	if (DQ_W < 1 || DQ_W > 16) begin : g_bad_width
		$error("dcp_mask_lane: DQ_W must lie between 1 and 16");
	end

	logic [DQ_W-1:0] en_next;

	// The x16 part splits into two bytes; narrower parts use only the low mask.
	always_comb begin
		en_next = '0;
		for (int b = 0; b < DQ_W; b++) begin
			if (b < 8) begin
				en_next[b] = ~mif.beat_mask[0];
			end else begin
				en_next[b] = ~mif.beat_mask[1];
			end
		end
	end

	// A masked beat still advances the burst but stores nothing in that byte.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mif.out_valid <= 1'b0;
			mif.out_data <= '0;
			mif.out_bit_en <= '0;
		end else begin
			mif.out_valid <= mif.beat_valid;
			mif.out_data <= mif.beat_data;
			mif.out_bit_en <= mif.beat_valid ? en_next : '0;
		end
	end
endmodule

/* dcp_ctrl_asserts.sv */
// Port-level checker for the control pin handling block.
`timescale 1ns/1ps
module dcp_ctrl_asserts #(
	parameter int DQ_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic clk_run_o,
	input wire dcp_pkg::dcp_pwr_t pwr_state_o,
	input wire logic [2:0] rx_en_o,
	input wire logic cmd_valid_o,
	input wire dcp_pkg::dcp_cmd_t cmd_o,
	input wire logic [DQ_W-1:0] term_en_o,
	input wire logic [1:0] term_mask_en_o,
	input wire logic wr_valid_o,
	input wire logic [DQ_W-1:0] wr_bit_en_o
);
	import dcp_pkg::*;
	// One clock domain, so clock and reset are given once for every property.
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Four samples leave room for the two synchroniser stages and the output register.
	a_clk_stop: assert property (!cke_i [*4] |=> !clk_run_o)
		else $error("clock kept running");
	a_clk_run: assert property (cke_i [*4] |=> clk_run_o)
		else $error("clock not running");
	a_pd_rx: assert property ((pwr_state_o inside {DCP_ST_PRE_PD, DCP_ST_ACT_PD})
		&& $stable(pwr_state_o) |-> rx_en_o == 3'h3) else $error("bad power-down receivers");
	a_sr_rx: assert property (pwr_state_o == DCP_ST_SELF_REF && $stable(pwr_state_o)
		|-> rx_en_o == 3'h1 && term_en_o == '0) else $error("bad self refresh receivers");
	a_cmd_select: assert property (cmd_valid_o |-> !$past(cs_n_i, 3) && $past(cke_i, 3))
		else $error("command passed while masked");
	a_cmd_code: assert property (cmd_valid_o
		|-> cmd_o == {1'b0, $past(ras_n_i, 3), $past(cas_n_i, 3), $past(we_n_i, 3)})
		else $error("wrong command code");
	a_lowpwr_quiet: assert property (pwr_state_o != DCP_ST_ACTIVE |-> !cmd_valid_o)
		else $error("command decoded in low power");
	a_term_group: assert property (term_mask_en_o == {2{term_en_o[0]}}
		&& (term_en_o == '0 || term_en_o == '1)) else $error("termination not uniform");
	a_mask_bytes: assert property (wr_valid_o |-> (wr_bit_en_o[7:0] inside {8'h00, 8'hFF})
		&& (wr_bit_en_o[15:8] inside {8'h00, 8'hFF})) else $error("mask split a byte");
	// Main scenarios that the bench is expected to reach.
	c_cmd: cover property (cmd_valid_o);
	c_sr: cover property (pwr_state_o == DCP_ST_SELF_REF);
	c_wr: cover property (wr_valid_o && wr_bit_en_o != '1);
endmodule

/* dcp_host_model.sv */
// Memory controller model that drives the command, enable, termination and write pins.
`timescale 1ns/1ps
module dcp_host_model (
	input wire logic ref_clk_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] rcw_n_o,
	output logic [2:0] ba_o,
	output logic [14:0] addr_o,
	output logic odt_o,
	output logic [15:0] dq_o,
	output logic [1:0] dm_o,
	output logic dqs_o
);
	// Pins start idle so the device sees no command while reset is applied.
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		rcw_n_o = 3'h7;
		ba_o = 3'h0;
		addr_o = 15'h0000;
		odt_o = 1'b0;
		dq_o = 16'h0000;
		dm_o = 2'h0;
		dqs_o = 1'b0;
	end
	// One command cycle with its clock enable level, then a no-operation.
	// A data bus that no write drives is inverted here rather than left looking stable.
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
		input logic k);
		@(posedge ref_clk_i);
		cs_n_o <= c[3];
		rcw_n_o <= c[2:0];
		ba_o <= b;
		addr_o <= a;
		cke_o <= k;
		dq_o <= ~dq_o;
		@(posedge ref_clk_i);
		cs_n_o <= 1'b0;
		rcw_n_o <= 3'h7;
	endtask
	// One write beat: the strobe toggles once, carrying data and mask.
	task automatic beat(input logic [15:0] d, input logic [1:0] m);
		@(posedge ref_clk_i);
		dq_o <= d;
		dm_o <= m;
		dqs_o <= ~dqs_o;
	endtask
endmodule

/* dcp_ctrl_tb_top.sv */
// Self-checking testbench for the control pin handling block.
`timescale 1ns/1ps
module dcp_ctrl_tb_top;
	import dcp_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	wire cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i, dqs_i;
	wire [2:0] ba_i;
	wire [14:0] addr_i;
	wire [15:0] dq_i;
	wire [1:0] dm_i;
	logic clk_run_o, cmd_valid_o, wr_valid_o;
	dcp_pwr_t pwr_state_o;
	dcp_cmd_t cmd_o;
	logic [2:0] rx_en_o, cmd_ba_o;
	logic [14:0] cmd_addr_o;
	logic [15:0] term_en_o, wr_data_o, wr_bit_en_o;
	logic [1:0] term_mask_en_o;
	int fails = 0;
	int n_checks = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	dcp_host_model dcp_host_model_inst (.ref_clk_i(ref_clk_i), .cke_o(cke_i), .cs_n_o(cs_n_i),
		.rcw_n_o({ras_n_i, cas_n_i, we_n_i}), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i),
		.dq_o(dq_i), .dm_o(dm_i), .dqs_o(dqs_i));
	dcp_ctrl #(.DQ_W(16)) dcp_ctrl_inst (.*);
	task automatic complete_run;
		if (fails == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Waits a bounded span for a decoded command pulse.
	task automatic wait_cmd(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 8 && !seen; i++) begin
			@(posedge ref_clk_i);
			#1;
			seen = cmd_valid_o === 1'b1;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Every command code, then a no-operation and a deselected activate.
	task automatic t_codes;
		logic s;
		for (int c = 0; c < 7; c++) begin
			dcp_host_model_inst.cmd(c[3:0], c[2:0], 15'h0400, 1'b1);
			wait_cmd(s);
			chk(s, 1'b1);
			chk(cmd_o, c[3:0]);
			chk(cmd_ba_o, c[2:0]);
			chk(cmd_addr_o, 15'h0400);
		end
		dcp_host_model_inst.cmd(4'h7, 3'h0, 15'h0000, 1'b1);
		wait_cmd(s);
		chk(s, 1'b0);
		dcp_host_model_inst.cmd(4'hB, 3'h0, 15'h0000, 1'b1);
		wait_cmd(s);
		chk(s, 1'b0);
	endtask
	// Termination input ignored until enabled by a mode load, and again once disabled.
	task automatic t_odt;
		@(posedge ref_clk_i);
		dcp_host_model_inst.odt_o <= 1'b1;
		cyc(6);
		chk(term_en_o, 16'h0000);
		dcp_host_model_inst.cmd(4'h0, 3'h1, 15'h0004, 1'b1);
		cyc(6);
		chk(term_en_o, 16'hFFFF);
		chk(term_mask_en_o, 2'h3);
		dcp_host_model_inst.cmd(4'h0, 3'h1, 15'h0000, 1'b1);
		cyc(6);
		chk(term_en_o, 16'h0000);
	endtask
	// Back-to-back beats masking each byte in turn, then none.
	task automatic t_write;
		logic s;
		logic [15:0] d[3] = '{16'hA5C3, 16'h3C5A, 16'h1234};
		logic [15:0] e[3] = '{16'hFF00, 16'h00FF, 16'hFFFF};
		int n;
		dcp_host_model_inst.cmd(4'h4, 3'h0, 15'h0000, 1'b1);
		wait_cmd(s);
		dcp_host_model_inst.beat(d[0], 2'h1);
		dcp_host_model_inst.beat(d[1], 2'h2);
		dcp_host_model_inst.beat(d[2], 2'h0);
		n = 0;
		repeat (10) begin
			cyc(1);
			if (wr_valid_o === 1'b1 && n < 3) begin
				chk(wr_bit_en_o, e[n]);
				chk(wr_data_o & e[n], d[n] & e[n]);
				n++;
			end
		end
		chk(n, 3);
	endtask
	// Both power-downs and self refresh, with entry and exit.
	task automatic t_power;
		logic s;
		dcp_host_model_inst.cmd(4'h2, 3'h0, 15'h0400, 1'b1);
		dcp_host_model_inst.cmd(4'h7, 3'h0, 15'h0000, 1'b0);
		cyc(6);
		chk(pwr_state_o, DCP_ST_PRE_PD);
		chk(rx_en_o, 3'h3);
		chk(clk_run_o, 1'b0);
		dcp_host_model_inst.cmd(4'h3, 3'h0, 15'h0000, 1'b0);
		wait_cmd(s);
		chk(s, 1'b0);
		dcp_host_model_inst.cmd(4'h7, 3'h0, 15'h0000, 1'b1);
		cyc(6);
		chk(pwr_state_o, DCP_ST_ACTIVE);
		chk(clk_run_o, 1'b1);
		dcp_host_model_inst.cmd(4'h3, 3'h1, 15'h0000, 1'b1);
		dcp_host_model_inst.cmd(4'h7, 3'h0, 15'h0000, 1'b0);
		cyc(6);
		chk(pwr_state_o, DCP_ST_ACT_PD);
		dcp_host_model_inst.cmd(4'h7, 3'h0, 15'h0000, 1'b1);
		cyc(6);
		chk(pwr_state_o, DCP_ST_ACTIVE);
		dcp_host_model_inst.cmd(4'h2, 3'h0, 15'h0400, 1'b1);
		dcp_host_model_inst.cmd(4'h1, 3'h0, 15'h0000, 1'b0);
		cyc(6);
		chk(pwr_state_o, DCP_ST_SELF_REF);
		chk(rx_en_o, 3'h1);
		dcp_host_model_inst.cmd(4'h7, 3'h0, 15'h0000, 1'b1);
		cyc(6);
		chk(pwr_state_o, DCP_ST_ACTIVE);
		chk(rx_en_o, 3'h7);
	endtask
	// Main sequence after ten cycles of reset.
	initial begin
		repeat (10) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		cyc(3);
		t_codes();
		t_odt();
		t_write();
		t_power();
		complete_run();
	end
	// Watchdog far beyond the fewer than two hundred cycles the tests need.
	initial begin
		#50000;
		fails++;
		complete_run();
	end
endmodule
bind dcp_ctrl dcp_ctrl_asserts #(.DQ_W(DQ_W)) dcp_ctrl_asserts_inst (.*);
